// File: rtl/dss_fault_tracker.sv
// Fault latch and power-on inhibit tracker.
// Assumes acknowledge arrives as a one-cycle pulse.
`timescale 1ns/10ps
`default_nettype none
module dss_fault_tracker (
  // Clock and reset
  input  wire logic i_clock,
  input  wire logic i_rst_n,
  // Causes and controls
  input  wire logic i_fault_cause,
  input  wire logic i_ack_pulse,
  input  wire logic i_cw_on,
  input  wire logic i_ack_wo_stop,
  // State
  output logic      o_fault_pending,
  output logic      o_pon_inhibit
);
  logic fault_ff;
  logic pon_ff;
  logic ack_ok;

  // Ack needs cause gone; ON low unless bypass chosen
  assign ack_ok = i_ack_pulse && !i_fault_cause && (!i_cw_on || i_ack_wo_stop);

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fault_ff <= 1'b0;
    end else if (i_fault_cause) begin
      fault_ff <= 1'b1;
    end else if (ack_ok) begin
      fault_ff <= 1'b0;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pon_ff <= 1'b1;
    end else if (fault_ff && ack_ok) begin
      pon_ff <= 1'b1;
    end else if (!i_cw_on) begin
      pon_ff <= 1'b0;
    end
  end

  assign o_fault_pending = fault_ff;
  assign o_pon_inhibit   = pon_ff;
endmodule
`default_nettype wire

// File: rtl/dss_pkg.sv
// Constants, register map and carrier types of the drive status signal generator.
// Assumes a 10 MHz system clock and an Avalon-MM slave with 32-bit data.
package dss_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLOCK_PERIOD_NS = 100;
  localparam int DWELL_UNIT_NS   = 1000000;
  localparam int DWELL_UNIT_CYC  = (DWELL_UNIT_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_CONFIG      = 8'h00;
  localparam logic [7:0] OFS_CONTROL_ONE = 8'h04;
  localparam logic [7:0] OFS_TOL_BAND    = 8'h08;
  localparam logic [7:0] OFS_TOL_DWELL   = 8'h0C;
  localparam logic [7:0] OFS_UV_LEVEL    = 8'h10;
  localparam logic [7:0] OFS_TERM_SELECT = 8'h14;
  localparam logic [7:0] OFS_STATUS_ONE  = 8'h18;
  localparam logic [7:0] OFS_STATUS_TWO  = 8'h1C;
  localparam logic [7:0] OFS_MESSAGE     = 8'h20;
  localparam logic [7:0] OFS_FAULT_ACK   = 8'h24;
  localparam logic [7:0] OFS_WARN_FIRST  = 8'h28;
  localparam logic [7:0] OFS_WARN_LAST   = 8'h34;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int CFG_READY_MEANING  = 0;
  localparam int CFG_ACK_WO_STOP    = 1;
  localparam int CFG_SPINDLE_SELECT = 2;
  localparam int CW_ON              = 0;
  localparam int CW_NO_COAST        = 1;
  localparam int CW_NO_QSTOP        = 2;
  localparam int CW_FAULT_ACK       = 7;
  localparam int CW_TORQUE_MODE     = 14;
  localparam int ACK_BIT            = 0;
  localparam logic [31:0] RST_CONFIG      = 32'h0000_0001;
  localparam logic [15:0] RST_CONTROL_ONE = 16'h0000;
  localparam logic [15:0] RST_TOL_BAND    = 16'h0010;
  localparam logic [15:0] RST_TOL_DWELL   = 16'h0014;
  localparam logic [15:0] RST_UV_LEVEL    = 16'h0000;
  localparam logic [15:0] RST_TERM_SELECT = 16'h0000;

  // Status bit positions
  localparam int SW1_READY_NOFAULT = 1;
  localparam int SW1_CTRL_ENABLE   = 2;
  localparam int SW1_FAULT         = 3;
  localparam int SW1_PON_INHIBIT   = 6;
  localparam int SW1_WARNING       = 7;
  localparam int SW1_SPEED_OR_NFE  = 8;
  localparam int SW1_TORQUE_MODE   = 14;
  localparam int SW1_SPINDLE_ON    = 15;
  localparam int SW2_BRAKE         = 5;
  localparam int SW2_PARKING       = 7;
  localparam int MW_DCLINK         = 4;
  localparam int MW_SPEED_REACHED  = 8;
  localparam int MW_NOT_LIMITED    = 10;
  localparam int MW_DRIVE_READY    = 12;
  localparam int MW_PULSES         = 13;

  // Output terminal function numbers
  localparam logic [5:0] FN_FIXED_BASE  = 6'd15;
  localparam logic [5:0] FN_SPEED_REACH = 6'd20;
  localparam logic [5:0] FN_SPINDLE_ON  = 6'd28;
  localparam logic [5:0] FN_NOT_LIMITED = 6'd37;
  localparam logic [5:0] FN_NO_FOLLOW   = 6'd58;

  // ----------------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic         speed_mode;
    logic [3:0]   fixed_setpoint;
    logic [15:0]  speed_set;
    logic [15:0]  speed_act;
    logic         spindle_active;
    logic         no_follow_error;
    logic [127:0] warnings;
    logic [15:0]  dclink_voltage;
    logic         fault_cause;
    logic         pulse_terminal;
    logic         speed_ctrl_active;
    logic         parking_request;
    logic         brake_release;
    logic         pulses_enabled;
    logic         fixed_stop_reached;
    logic         current_limited;
  } dss_drive_in_s;

  typedef struct packed {
    logic         read;
    logic         write;
    logic [7:0]   address;
    logic [3:0]   byteenable;
    logic [31:0]  writedata;
  } dss_bus_req_s;

  typedef enum logic [1:0] {ST_OUTSIDE, ST_DWELL, ST_REACHED} dss_reach_e;

endpackage

// File: rtl/dss_speed_reached.sv
// Speed-reached detector: tolerance band entry plus dwell timer.
// Assumes band and dwell are stable configuration values from registers.
`timescale 1ns/10ps
`default_nettype none
module dss_speed_reached
  import dss_pkg::*;
#(
  parameter int CYCLES_PER_UNIT = DWELL_UNIT_CYC
) (
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  // Speeds and limits
  input  wire logic [15:0] i_speed_set,
  input  wire logic [15:0] i_speed_act,
  input  wire logic [15:0] i_band,
  input  wire logic [15:0] i_dwell,
  // Result
  output logic             o_reached
);
  logic [15:0] diff;
  logic        in_band;
  logic [31:0] pre_ff;
  logic [15:0] units_ff;
  dss_reach_e  state_ff;

  assign diff    = (i_speed_act > i_speed_set) ? i_speed_act - i_speed_set : i_speed_set - i_speed_act;
  assign in_band = (diff <= i_band);

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff <= ST_OUTSIDE;
      pre_ff   <= 32'h0000_0000;
      units_ff <= 16'h0000;
    end else if (!in_band) begin
      state_ff <= ST_OUTSIDE;
      pre_ff   <= 32'h0000_0000;
      units_ff <= 16'h0000;
    end else begin
      unique case (state_ff)
        ST_OUTSIDE: begin
          state_ff <= (i_dwell == 16'h0000) ? ST_REACHED : ST_DWELL;
        end
        ST_DWELL: begin
          if (pre_ff == 32'(CYCLES_PER_UNIT - 1)) begin
            pre_ff   <= 32'h0000_0000;
            units_ff <= units_ff + 16'h0001;
            if (units_ff + 16'h0001 >= i_dwell) begin
              state_ff <= ST_REACHED;
            end
          end else begin
            pre_ff <= pre_ff + 32'h0000_0001;
          end
        end
        ST_REACHED: state_ff <= ST_REACHED;
      endcase
    end
  end

  assign o_reached = (state_ff == ST_REACHED);
endmodule
`default_nettype wire

// File: rtl/dss_status_gen.sv
// Drive status signal generator: status words, message word, output terminals.
// Assumes Avalon-MM master with waitrequest and synchronous drive inputs.
//
// Summary of operation
// - Fixed setpoint number on functions 15-18 in speed mode.
// - Two programmable output terminals.
// - Speed reached after band entry and dwell.
// - Spindle select makes bit 8 no-following-error.
// - Spindle positioning active shown in speed mode.
// - Warning flag; warnings readable in four words.
// - DC link compared against undervoltage level.
// - Fault latched until cause gone and acknowledged.
// - Controller enable while speed controller active.
// - Config bit selects ready or no-fault meaning.
// - Ready needs no fault, terminal, control bits.
// - No-fault passed to line infeed module.
// - Optional acknowledge without ON low, inhibit stays.
// - Parking shown; encoder monitoring disabled.
// - Brake contactor output from internal sequence.
// - Pulses-enabled status follows pulse state.
// - Drive-ready feedback bit in message word.
// - Torque mode from control word bit 14 in speed mode.
// - Fixed stop reached sets torque mode outside speed mode.
// - Current-not-limited status from i2t limiting.
`timescale 1ns/10ps
`default_nettype none
module dss_status_gen
  import dss_pkg::*;
#(
  parameter int CYCLES_PER_UNIT = DWELL_UNIT_CYC
) (
  // Clock and reset
  input  wire logic          i_clock,
  input  wire logic          i_rst_n,
  // Avalon-MM slave
  input  wire dss_bus_req_s  i_bus,
  output logic               o_waitrequest,
  output logic [31:0]        o_readdata,
  // Drive core state
  input  wire dss_drive_in_s i_drive,
  // Status outputs
  output logic [15:0]        o_status_word_one,
  output logic [15:0]        o_status_word_two,
  output logic [15:0]        o_message_word,
  output logic [1:0]         o_terminal,
  output logic               o_infeed_no_fault,
  output logic               o_encoder_monitor_disable,
  output logic               o_brake_contactor
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic pick_function(input logic [5:0] fn, input logic [63:0] sig);
    return sig[fn];
  endfunction

  // ----------------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------------
  logic        req;
  logic        ack_ff;
  logic        wr_go;
  logic [31:0] readdata_ff;
  logic [31:0] nxt_readdata;

  assign req           = i_bus.read || i_bus.write;
  assign o_waitrequest = req && !ack_ff;
  assign wr_go         = i_bus.write && ack_ff;
  assign o_readdata    = readdata_ff;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req && !ack_ff;
    end
  end

  // ----------------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------------
  logic [31:0] config_ff;
  logic [15:0] control_one_ff;
  logic [15:0] tol_band_ff;
  logic [15:0] tol_dwell_ff;
  logic [15:0] uv_level_ff;
  logic [15:0] term_select_ff;
  logic        reg_ack_ff;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      config_ff      <= RST_CONFIG;
      control_one_ff <= RST_CONTROL_ONE;
      tol_band_ff    <= RST_TOL_BAND;
      tol_dwell_ff   <= RST_TOL_DWELL;
      uv_level_ff    <= RST_UV_LEVEL;
      term_select_ff <= RST_TERM_SELECT;
    end else if (wr_go) begin
      unique case (i_bus.address)
        OFS_CONFIG: begin
          config_ff <= merge_bytes(config_ff, i_bus.writedata, i_bus.byteenable);
        end
        OFS_CONTROL_ONE: begin
          control_one_ff <= 16'(merge_bytes({16'h0000, control_one_ff}, i_bus.writedata, i_bus.byteenable));
        end
        OFS_TOL_BAND: begin
          tol_band_ff <= 16'(merge_bytes({16'h0000, tol_band_ff}, i_bus.writedata, i_bus.byteenable));
        end
        OFS_TOL_DWELL: begin
          tol_dwell_ff <= 16'(merge_bytes({16'h0000, tol_dwell_ff}, i_bus.writedata, i_bus.byteenable));
        end
        OFS_UV_LEVEL: begin
          uv_level_ff <= 16'(merge_bytes({16'h0000, uv_level_ff}, i_bus.writedata, i_bus.byteenable));
        end
        OFS_TERM_SELECT: begin
          term_select_ff <= 16'(merge_bytes({16'h0000, term_select_ff}, i_bus.writedata, i_bus.byteenable));
        end
        default: begin
        end
      endcase
    end
  end

  // Acknowledge from register write or control word bit 7 rising edge
  logic cw_ack_prev_ff;
  logic ack_pulse;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      reg_ack_ff     <= 1'b0;
      cw_ack_prev_ff <= 1'b0;
    end else begin
      reg_ack_ff     <= wr_go && (i_bus.address == OFS_FAULT_ACK) && i_bus.byteenable[0]
                        && i_bus.writedata[ACK_BIT];
      cw_ack_prev_ff <= control_one_ff[CW_FAULT_ACK];
    end
  end

  assign ack_pulse = reg_ack_ff || (control_one_ff[CW_FAULT_ACK] && !cw_ack_prev_ff);

  // ----------------------------------------------------------------------
  // Sub-blocks
  // ----------------------------------------------------------------------
  logic speed_reached;
  logic fault_pending;
  logic pon_inhibit;

  dss_speed_reached #(
    .CYCLES_PER_UNIT (CYCLES_PER_UNIT)
  ) u_reach (
    .i_clock     (i_clock),
    .i_rst_n     (i_rst_n),
    .i_speed_set (i_drive.speed_set),
    .i_speed_act (i_drive.speed_act),
    .i_band      (tol_band_ff),
    .i_dwell     (tol_dwell_ff),
    .o_reached   (speed_reached)
  );

  dss_fault_tracker u_fault (
    .i_clock         (i_clock),
    .i_rst_n         (i_rst_n),
    .i_fault_cause   (i_drive.fault_cause),
    .i_ack_pulse     (ack_pulse),
    .i_cw_on         (control_one_ff[CW_ON]),
    .i_ack_wo_stop   (config_ff[CFG_ACK_WO_STOP]),
    .o_fault_pending (fault_pending),
    .o_pon_inhibit   (pon_inhibit)
  );

  // ----------------------------------------------------------------------
  // Derived status
  // ----------------------------------------------------------------------
  logic        speed_mode;
  logic        warning_any;
  logic        dclink_ok;
  logic        drive_ready;
  logic        ready_or_nofault;
  logic        torque_mode;
  logic        bit8_value;
  logic        spindle_on;
  logic [3:0]  fixed_num;
  logic [63:0] fn_sig;

  assign speed_mode  = i_drive.speed_mode;
  assign warning_any = |i_drive.warnings;
  assign dclink_ok   = (i_drive.dclink_voltage > uv_level_ff);
  assign drive_ready = !fault_pending && i_drive.pulse_terminal
                       && control_one_ff[CW_ON] && control_one_ff[CW_NO_COAST]
                       && control_one_ff[CW_NO_QSTOP];
  assign ready_or_nofault = config_ff[CFG_READY_MEANING] ? drive_ready : !fault_pending;
  assign torque_mode = speed_mode ? control_one_ff[CW_TORQUE_MODE]
                                  : i_drive.fixed_stop_reached;
  assign spindle_on  = speed_mode && i_drive.spindle_active;
  assign fixed_num   = speed_mode ? i_drive.fixed_setpoint : 4'h0;
  assign bit8_value  = (!speed_mode || config_ff[CFG_SPINDLE_SELECT])
                       ? i_drive.no_follow_error : speed_reached;

  always_comb begin
    fn_sig = 64'h0000_0000_0000_0000;
    for (int i = 0; i < 4; i++) begin
      fn_sig[int'(FN_FIXED_BASE) + i] = fixed_num[i];
    end
    fn_sig[FN_SPEED_REACH]     = speed_mode && speed_reached;
    fn_sig[FN_SPINDLE_ON]      = spindle_on;
    fn_sig[FN_SPINDLE_ON + 1]  = warning_any;
    fn_sig[FN_SPINDLE_ON + 2]  = dclink_ok;
    fn_sig[FN_SPINDLE_ON + 3]  = fault_pending;
    fn_sig[FN_SPINDLE_ON + 4]  = i_drive.speed_ctrl_active;
    fn_sig[FN_SPINDLE_ON + 5]  = ready_or_nofault;
    fn_sig[FN_SPINDLE_ON + 6]  = i_drive.parking_request;
    fn_sig[FN_SPINDLE_ON + 7]  = i_drive.brake_release && i_drive.pulses_enabled;
    fn_sig[FN_SPINDLE_ON + 8]  = i_drive.pulses_enabled;
    fn_sig[FN_NOT_LIMITED]     = !i_drive.current_limited;
    fn_sig[FN_NO_FOLLOW]       = !speed_mode && i_drive.no_follow_error;
  end

  // ----------------------------------------------------------------------
  // Status word and output registers
  // ----------------------------------------------------------------------
  logic [15:0] nxt_sw1;
  logic [15:0] nxt_sw2;
  logic [15:0] nxt_mw;
  logic [15:0] sw1_ff;
  logic [15:0] sw2_ff;
  logic [15:0] mw_ff;
  logic [1:0]  terminal_ff;
  logic        infeed_ff;
  logic        park_ff;
  logic        brake_ff;

  always_comb begin
    nxt_sw1 = 16'h0000;
    nxt_sw2 = 16'h0000;
    nxt_mw  = 16'h0000;
    nxt_sw1[SW1_READY_NOFAULT] = ready_or_nofault;
    nxt_sw1[SW1_CTRL_ENABLE]   = i_drive.speed_ctrl_active;
    nxt_sw1[SW1_FAULT]         = fault_pending;
    nxt_sw1[SW1_PON_INHIBIT]   = pon_inhibit;
    nxt_sw1[SW1_WARNING]       = warning_any;
    nxt_sw1[SW1_SPEED_OR_NFE]  = bit8_value;
    nxt_sw1[SW1_TORQUE_MODE]   = torque_mode;
    nxt_sw1[SW1_SPINDLE_ON]    = spindle_on;
    nxt_sw2[SW2_BRAKE]         = fn_sig[FN_SPINDLE_ON + 7];
    nxt_sw2[SW2_PARKING]       = i_drive.parking_request;
    nxt_mw[MW_DCLINK]          = dclink_ok;
    nxt_mw[MW_SPEED_REACHED]   = speed_reached;
    nxt_mw[MW_NOT_LIMITED]     = !i_drive.current_limited;
    nxt_mw[MW_DRIVE_READY]     = drive_ready && !pon_inhibit;
    nxt_mw[MW_PULSES]          = i_drive.pulses_enabled;
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sw1_ff <= 16'h0000;
      sw2_ff <= 16'h0000;
      mw_ff  <= 16'h0000;
    end else begin
      sw1_ff <= nxt_sw1;
      sw2_ff <= nxt_sw2;
      mw_ff  <= nxt_mw;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      terminal_ff <= 2'b00;
      infeed_ff   <= 1'b0;
      park_ff     <= 1'b0;
      brake_ff    <= 1'b0;
    end else begin
      terminal_ff[0] <= pick_function(term_select_ff[5:0], fn_sig);
      terminal_ff[1] <= pick_function(term_select_ff[13:8], fn_sig);
      infeed_ff      <= !fault_pending;
      park_ff        <= i_drive.parking_request;
      brake_ff       <= fn_sig[FN_SPINDLE_ON + 7];
    end
  end

  assign o_status_word_one         = sw1_ff;
  assign o_status_word_two         = sw2_ff;
  assign o_message_word            = mw_ff;
  assign o_terminal                = terminal_ff;
  assign o_infeed_no_fault         = infeed_ff;
  assign o_encoder_monitor_disable = park_ff;
  assign o_brake_contactor         = brake_ff;

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_readdata = 32'h0000_0000;
    unique case (i_bus.address)
      OFS_CONFIG:      nxt_readdata = config_ff;
      OFS_CONTROL_ONE: nxt_readdata = {16'h0000, control_one_ff};
      OFS_TOL_BAND:    nxt_readdata = {16'h0000, tol_band_ff};
      OFS_TOL_DWELL:   nxt_readdata = {16'h0000, tol_dwell_ff};
      OFS_UV_LEVEL:    nxt_readdata = {16'h0000, uv_level_ff};
      OFS_TERM_SELECT: nxt_readdata = {16'h0000, term_select_ff};
      OFS_STATUS_ONE:  nxt_readdata = {16'h0000, sw1_ff};
      OFS_STATUS_TWO:  nxt_readdata = {16'h0000, sw2_ff};
      OFS_MESSAGE:     nxt_readdata = {16'h0000, mw_ff};
      OFS_WARN_FIRST:  nxt_readdata = i_drive.warnings[31:0];
      OFS_WARN_FIRST + 8'h04: nxt_readdata = i_drive.warnings[63:32];
      OFS_WARN_FIRST + 8'h08: nxt_readdata = i_drive.warnings[95:64];
      OFS_WARN_LAST:   nxt_readdata = i_drive.warnings[127:96];
      default:         nxt_readdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      readdata_ff <= 32'h0000_0000;
    end else if (i_bus.read && !ack_ff) begin
      readdata_ff <= nxt_readdata;
    end
  end

endmodule
`default_nettype wire

// File: verif/dss_checker.sv
// Assertions on the status generator ports.
// Assumes a bind onto dss_status_gen.
`timescale 1ns/10ps
`default_nettype none
module dss_checker
  import dss_pkg::*;
(
  // Clock, reset and bus
  input wire logic          i_clock,
  input wire logic          i_rst_n,
  input wire dss_bus_req_s  i_bus,
  input wire logic          o_waitrequest,
  // Drive state and status
  input wire dss_drive_in_s i_drive,
  input wire logic [15:0]   o_status_word_one,
  input wire logic [15:0]   o_status_word_two,
  input wire logic [15:0]   o_message_word,
  input wire logic          o_infeed_no_fault,
  input wire logic          o_encoder_monitor_disable,
  input wire logic          o_brake_contactor
);
  // --------------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------------
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  property p_wait; $rose(i_bus.read | i_bus.write) |-> o_waitrequest ##1 !o_waitrequest; endproperty
  property p_fault; i_drive.fault_cause |-> ##2 o_status_word_one[SW1_FAULT]; endproperty
  property p_infeed; o_status_word_one[SW1_FAULT] |-> !o_infeed_no_fault; endproperty
  property p_warn; i_rst_n |=> o_status_word_one[SW1_WARNING] == $past(|i_drive.warnings); endproperty
  property p_spin; i_drive.speed_mode |=> o_status_word_one[SW1_SPINDLE_ON] == $past(i_drive.spindle_active);
  endproperty
  property p_ctrl; i_rst_n |=> o_status_word_one[SW1_CTRL_ENABLE] == $past(i_drive.speed_ctrl_active); endproperty
  property p_park; o_encoder_monitor_disable == o_status_word_two[SW2_PARKING]; endproperty
  property p_brake; o_brake_contactor |-> o_message_word[MW_PULSES]; endproperty
  property p_limit; i_rst_n |=> o_message_word[MW_NOT_LIMITED] != $past(i_drive.current_limited); endproperty
  property p_stop; !i_drive.speed_mode && i_drive.fixed_stop_reached |=> o_status_word_one[SW1_TORQUE_MODE];
  endproperty
  a_wait: assert property (p_wait) else $error("bus wait wrong");
  a_fault: assert property (p_fault) else $error("fault flag late");
  a_infeed: assert property (p_infeed) else $error("infeed flag wrong");
  a_warn: assert property (p_warn) else $error("warning flag wrong");
  a_spin: assert property (p_spin) else $error("spindle flag wrong");
  a_ctrl: assert property (p_ctrl) else $error("enable flag wrong");
  a_park: assert property (p_park) else $error("parking flag wrong");
  a_brake: assert property (p_brake) else $error("brake without pulses");
  a_limit: assert property (p_limit) else $error("limit flag wrong");
  a_stop: assert property (p_stop) else $error("torque flag late");
  c_fault: cover property (o_status_word_one[SW1_FAULT]);
  c_park: cover property (o_encoder_monitor_disable);
  c_brake: cover property (o_brake_contactor);
endmodule
`default_nettype wire

// File: verif/dss_far_side.sv
// Armature short-circuit contactor logic outside the drive.
// Assumes the message word of the drive as input.
`timescale 1ns/10ps
`default_nettype none
module dss_far_side
  import dss_pkg::*;
(
  // Status from the drive
  input  wire logic [15:0] i_message_word,
  // Contactor coil
  output logic             o_short_circuit
);
  // Energized only while pulses are inhibited
  assign o_short_circuit = !i_message_word[MW_PULSES];
endmodule
`default_nettype wire

// File: verif/testbench.sv
// Self-checking bench of the status generator.
// Assumes a 10 MHz clock and a dwell unit of four cycles.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import dss_pkg::*;
  logic          clk, rst_n, wait_r, infeed, enc_off, brake, short_on;
  dss_bus_req_s  bus;
  dss_drive_in_s drv;
  logic [31:0]   rdata, q;
  logic [15:0]   sw1, sw2, mw;
  logic [1:0]    term;
  int            fails, samples_checked;
  dss_status_gen #(.CYCLES_PER_UNIT(4)) dut (.i_clock(clk), .i_rst_n(rst_n), .i_bus(bus),
    .o_waitrequest(wait_r), .o_readdata(rdata), .i_drive(drv), .o_status_word_one(sw1),
    .o_status_word_two(sw2), .o_message_word(mw), .o_terminal(term), .o_infeed_no_fault(infeed),
    .o_encoder_monitor_disable(enc_off), .o_brake_contactor(brake));
  dss_far_side far (.i_message_word(mw), .o_short_circuit(short_on));
  // --------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    bus <= '{read: !w, write: w, address: a, byteenable: 4'hF, writedata: d};
    @(posedge clk);
    while (wait_r !== 1'h0) begin
      n++;
      if (n > 20) begin
        fails++;
        $display("[FAIL] %0t bus timeout", $time);
        end_of_test();
      end
      @(posedge clk);
    end
    q = rdata;
    bus <= '0;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  // --------------------------------------------------------------------
  // Sequence
  // --------------------------------------------------------------------
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  initial begin
    bus = '0;
    drv = '0;
    rst_n = 1'h0;
    fails = 0;
    samples_checked = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'h1;
    acc(0, OFS_CONFIG, 0);
    chk(q, 32'h0000_0001);
    acc(0, OFS_TOL_DWELL, 0);
    chk(q, 32'h0000_0014);
    acc(0, 8'h3C, 0);
    chk(q, 32'h0000_0000);
    chk(sw1[SW1_PON_INHIBIT], 1'h0);
    chk(mw[MW_DCLINK], 1'h0);
    $display("reset test done");
    acc(1, OFS_TERM_SELECT, 32'h0000_120F);
    drv.speed_mode <= 1'h1;
    for (int k = 0; k < 16; k++) begin
      @(posedge clk);
      drv.fixed_setpoint <= k[3:0];
      settle(2);
      chk(term, {k[3], k[0]});
    end
    @(posedge clk);
    drv.speed_set <= 16'h0064;
    acc(1, OFS_TOL_BAND, 32'h0000_0002);
    acc(1, OFS_TOL_DWELL, 32'h0000_0001);
    drv.speed_act <= 16'h0066;
    settle(2);
    chk(mw[MW_SPEED_REACHED], 1'h0);
    settle(8);
    chk(mw[MW_SPEED_REACHED], 1'h1);
    acc(1, OFS_CONFIG, 32'h0000_0005);
    settle(2);
    chk(sw1[SW1_SPEED_OR_NFE], 1'h0);
    $display("setpoint test done");
    @(posedge clk);
    drv.fault_cause <= 1'h1;
    drv.warnings[100] <= 1'h1;
    drv.parking_request <= 1'h1;
    settle(3);
    chk(sw1[SW1_FAULT], 1'h1);
    chk(infeed, 1'h0);
    acc(0, OFS_WARN_LAST, 0);
    chk(q, 32'h0000_0010);
    chk(enc_off, 1'h1);
    chk(sw2[SW2_PARKING], 1'h1);
    acc(1, OFS_FAULT_ACK, 32'h0000_0001);
    settle(3);
    chk(sw1[SW1_FAULT], 1'h1);
    @(posedge clk);
    drv.fault_cause <= 1'h0;
    drv.pulse_terminal <= 1'h1;
    acc(1, OFS_CONTROL_ONE, 32'h0000_0007);
    acc(1, OFS_FAULT_ACK, 32'h0000_0001);
    settle(3);
    chk(sw1[SW1_FAULT], 1'h1);
    acc(1, OFS_CONFIG, 32'h0000_0007);
    acc(1, OFS_FAULT_ACK, 32'h0000_0001);
    settle(3);
    chk(sw1[SW1_FAULT], 1'h0);
    chk(sw1[SW1_PON_INHIBIT], 1'h1);
    chk(sw1[SW1_READY_NOFAULT], 1'h1);
    chk(infeed, 1'h1);
    $display("fault test done");
    acc(1, OFS_CONTROL_ONE, 32'h0000_4003);
    drv.pulses_enabled <= 1'h1;
    drv.brake_release <= 1'h1;
    drv.speed_ctrl_active <= 1'h1;
    drv.spindle_active <= 1'h1;
    drv.dclink_voltage <= 16'h0200;
    settle(2);
    chk(sw1[SW1_READY_NOFAULT], 1'h0);
    chk(sw1[SW1_TORQUE_MODE], 1'h1);
    chk(short_on, 1'h0);
    chk(mw[MW_DCLINK], 1'h1);
    chk(mw[MW_DRIVE_READY], 1'h0);
    chk(brake, 1'h1);
    chk(sw2[SW2_BRAKE], 1'h1);
    acc(1, OFS_CONFIG, 32'h0000_0006);
    drv.current_limited <= 1'h1;
    drv.speed_mode <= 1'h0;
    drv.fixed_stop_reached <= 1'h1;
    settle(2);
    chk(sw1[SW1_READY_NOFAULT], 1'h1);
    chk(sw1[SW1_TORQUE_MODE], 1'h1);
    chk(mw[MW_NOT_LIMITED], 1'h0);
    $display("mode test done");
    end_of_test();
  end
endmodule
bind dss_status_gen dss_checker u_chk (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_bus(i_bus),
  .o_waitrequest(o_waitrequest), .i_drive(i_drive), .o_status_word_one(o_status_word_one),
  .o_status_word_two(o_status_word_two), .o_message_word(o_message_word),
  .o_infeed_no_fault(o_infeed_no_fault), .o_encoder_monitor_disable(o_encoder_monitor_disable),
  .o_brake_contactor(o_brake_contactor));
`default_nettype wire
